// *** core/dpll_pkg.sv ***
// package: constants and carrier types for the dual synthesizer control core
package dpll_pkg;
  // ---------------------------------------------------------------------------
  // widths and frame layout
  // ---------------------------------------------------------------------------
  localparam int REF_W       = 14;
  localparam int MAIN_W      = 11;
  localparam int SWAL_W      = 7;
  localparam int FRAME_LEN   = 24;
  // reference frame, bit 0 is the last bit shifted in
  localparam int RF_DEST_LO  = 0;
  localparam int RF_COUNT_LO = 2;
  localparam int RF_PRE      = 16;
  localparam int RF_POL      = 17;
  localparam int RF_CUR      = 18;
  localparam int RF_LDS      = 19;
  localparam int RF_MON1     = 20;
  localparam int RF_MON2     = 21;
  // counter frame
  localparam int CF_SWAL_LO  = 2;
  localparam int CF_MAIN_LO  = 9;
  // ---------------------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [13:0] REF_RESET  = 14'h0003;
  localparam logic [10:0] MAIN_RESET = 11'h003;
  localparam logic [6:0]  SWAL_RESET = 7'h00;
  localparam int LOCK_UP_CYC   = 2;   // unlock when error reaches this
  localparam int LOCK_LO_CYC   = 4;   // lock window in reference cycles
  localparam int LOCK_GOOD_CNT = 3;   // consecutive good comparisons
  localparam int ANTI_DEAD_CYC = 1;   // minimum pump pulse width
  localparam int SOFT_CYC      = 8;   // pump pulse limit after restart
  localparam int SOFT_CMP      = 4;   // comparisons with the limit on
  localparam logic [1:0] PRE_TX_HI  = 2'd0;  // 16/17
  localparam logic [1:0] PRE_MID    = 2'd1;  // 32/33
  localparam logic [1:0] PRE_RX_LO  = 2'd2;  // 64/65
  // ---------------------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [13:0] ref_count;
    logic        prescaler_mode;
    logic        phase_polarity;
    logic        pump_current_select;
  } dpll_ref_t;
  typedef struct packed {
    logic [10:0] main_count;
    logic [6:0]  swallow_count;
  } dpll_cnt_t;
  typedef struct packed {
    logic up;       // pump drives high
    logic down;     // pump drives low
    logic oe;       // pump drives at all
  } dpll_pump_t;
  typedef enum logic [1:0] {
    DPLL_DST_TXREF = 2'b00,
    DPLL_DST_TXCNT = 2'b01,
    DPLL_DST_RXREF = 2'b10,
    DPLL_DST_RXCNT = 2'b11
  } dpll_dest_t;
endpackage

// *** core/dpll_ctrl.sv ***
// file: serial loader, dividers, phase detector and lock logic
`timescale 1ns/100ps
// Behaviour
// - frames shift in most significant bit first
// - reference divider takes 14-bit binary ratio
// - main counter takes 11-bit ratio 3..2047
// - swallow counter takes 7-bit value 0..127
// - prescaler_mode picks the dual-modulus pair
// - lockdet_out_select low shows lock detect
// - monitor bits route divided frequency out
// - phase_polarity swaps pump high/low sense
// - pump_current_select picks high or low current
// - power_save_n low enters power saving
// - pump floats during power saving
// - pump error limited after power save release
// - short pulses on pump avoid dead zone
// - lock drops when error reaches two cycles
// - lock returns after three good comparisons
// - clock edge shifts, strobe edge latches
// - destination bits select the target latch
module dpll_ctrl #(
  parameter int FRAME_LEN = dpll_pkg::FRAME_LEN
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               serial_data,
  input  wire logic               serial_clock,
  input  wire logic               load_strobe,
  input  wire logic               power_save_n,
  input  wire logic [1:0]         comp_in,        // divided vco edges tx,rx
  output logic [1:0]              tx_prescaler_mod,
  output logic [1:0]              rx_prescaler_mod,
  output dpll_pkg::dpll_pump_t    tx_pump,
  output dpll_pkg::dpll_pump_t    rx_pump,
  output logic                    tx_pump_high_current,
  output logic                    rx_pump_high_current,
  output logic                    lock_monitor_out,
  output logic                    lock_detect
);
  initial begin
    if (FRAME_LEN < 22 || FRAME_LEN > 32)
      $error("frame length out of range");
  end

  // ---------------------------------------------------------------------------
  // synchronisers for pins
  // ---------------------------------------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       sclk_d;
  logic       le_d;
  logic [1:0] comp_d;
  // first stage feeds only the second stage
  always_ff @(posedge mclk)
  begin
    sync_a <= {comp_in, load_strobe, serial_clock};
    sync_b <= sync_a;
  end
  logic sdata_a;
  logic sdata_b;
  logic ps_a;
  logic ps_b;
  always_ff @(posedge mclk)
  begin
    sdata_a <= serial_data;
    sdata_b <= sdata_a;
    ps_a    <= power_save_n;
    ps_b    <= ps_a;
  end
  // previous synced values for edge detect
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      sclk_d <= 1'b0;
      le_d   <= 1'b0;
      comp_d <= 2'b00;
    end
    else
    begin
      sclk_d <= sync_b[0];
      le_d   <= sync_b[1];
      comp_d <= sync_b[3:2];
    end
  end
  wire       sclk_rise = sync_b[0] & ~sclk_d;
  wire       le_rise   = sync_b[1] & ~le_d;
  wire [1:0] comp_rise = sync_b[3:2] & ~comp_d;
  wire       active    = ps_b;

  // ---------------------------------------------------------------------------
  // shift register and latches
  // ---------------------------------------------------------------------------
  logic [FRAME_LEN-1:0] shift;
  dpll_pkg::dpll_ref_t  tx_ref;
  dpll_pkg::dpll_ref_t  rx_ref;
  dpll_pkg::dpll_cnt_t  tx_cnt;
  dpll_pkg::dpll_cnt_t  rx_cnt;
  logic                 lockdet_out_select;
  logic [1:0]           mon_sel;
  dpll_pkg::dpll_dest_t dest;
  assign dest = dpll_pkg::dpll_dest_t'(
    {shift[dpll_pkg::RF_DEST_LO], shift[dpll_pkg::RF_DEST_LO+1]});
  // new bits enter at the bottom, so the first bit ends up on top
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      shift <= '0;
    else if (sclk_rise)
      shift <= {shift[FRAME_LEN-2:0], sdata_b};
  end
  function automatic dpll_pkg::dpll_ref_t ref_field(
    input logic [FRAME_LEN-1:0] f);
    dpll_pkg::dpll_ref_t r;
    r.ref_count = f[dpll_pkg::RF_COUNT_LO +: dpll_pkg::REF_W];
    r.prescaler_mode      = f[dpll_pkg::RF_PRE];
    r.phase_polarity      = f[dpll_pkg::RF_POL];
    r.pump_current_select = f[dpll_pkg::RF_CUR];
    return r;
  endfunction
  function automatic dpll_pkg::dpll_cnt_t cnt_field(
    input logic [FRAME_LEN-1:0] f);
    dpll_pkg::dpll_cnt_t c;
    c.main_count    = f[dpll_pkg::CF_MAIN_LO +: dpll_pkg::MAIN_W];
    c.swallow_count = f[dpll_pkg::CF_SWAL_LO +: dpll_pkg::SWAL_W];
    return c;
  endfunction
  // latches load even in power save and are kept there
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tx_ref  <= '{dpll_pkg::REF_RESET, 1'b0, 1'b1, 1'b0};
      rx_ref  <= '{dpll_pkg::REF_RESET, 1'b0, 1'b1, 1'b0};
      tx_cnt  <= '{dpll_pkg::MAIN_RESET, dpll_pkg::SWAL_RESET};
      rx_cnt  <= '{dpll_pkg::MAIN_RESET, dpll_pkg::SWAL_RESET};
      lockdet_out_select     <= 1'b0;
      mon_sel <= 2'b00;
    end
    else if (le_rise)
    begin
      case (dest)
        dpll_pkg::DPLL_DST_TXREF:
        begin
          tx_ref  <= ref_field(shift);
          lockdet_out_select     <= shift[dpll_pkg::RF_LDS];
          mon_sel <= {shift[dpll_pkg::RF_MON1], shift[dpll_pkg::RF_MON2]};
        end
        dpll_pkg::DPLL_DST_RXREF: rx_ref <= ref_field(shift);
        dpll_pkg::DPLL_DST_TXCNT: tx_cnt <= cnt_field(shift);
        dpll_pkg::DPLL_DST_RXCNT: rx_cnt <= cnt_field(shift);
        default: tx_ref <= tx_ref;
      endcase
    end
  end
  // prescaler modulus code per side
  assign tx_prescaler_mod = tx_ref.prescaler_mode ? dpll_pkg::PRE_TX_HI
                                                  : dpll_pkg::PRE_MID;
  assign rx_prescaler_mod = rx_ref.prescaler_mode ? dpll_pkg::PRE_MID
                                                  : dpll_pkg::PRE_RX_LO;
  assign tx_pump_high_current = tx_ref.pump_current_select;
  assign rx_pump_high_current = rx_ref.pump_current_select;

  // ---------------------------------------------------------------------------
  // reference dividers, phase detectors, lock detect (one per side)
  // ---------------------------------------------------------------------------
  logic [1:0]  ref_tick;
  logic [1:0]  lock_side;
  logic [13:0] ref_cnt [2];
  logic [7:0]  err_cnt [2];
  logic [1:0]  lead;          // 1: reference came first
  logic [1:0]  pend;
  logic [1:0]  pump_up;
  logic [1:0]  pump_dn;
  logic [1:0]  pump_oe;
  logic [1:0]  good_cnt [2];
  logic [2:0]  soft_cnt [2];
  logic [13:0] ratio [2];
  logic [1:0]  pol;
  assign ratio[0] = tx_ref.ref_count;
  assign ratio[1] = rx_ref.ref_count;
  assign pol      = {rx_ref.phase_polarity, tx_ref.phase_polarity};
  for (genvar s = 0; s < 2; s++)
  begin : g_side
    // divider restarts on power save release
    always_ff @(posedge mclk)
    begin
      if (!reset_n || !active)
        ref_cnt[s] <= 14'h0001;
      else if (ref_cnt[s] >= ratio[s])
        ref_cnt[s] <= 14'h0001;
      else
        ref_cnt[s] <= ref_cnt[s] + 14'h0001;
    end
    assign ref_tick[s] = active && ref_cnt[s] >= ratio[s];
    // error window: opened by first edge, closed by the next edge of either kind
    wire ev_r = ref_tick[s];
    wire ev_p = comp_rise[s];
    always_ff @(posedge mclk)
    begin
      if (!reset_n || !active)
      begin
        pend[s] <= 1'b0;
        lead[s] <= 1'b0;
        err_cnt[s] <= 8'h00;
        good_cnt[s] <= 2'd0;
        soft_cnt[s] <= 3'd0;
        lock_side[s] <= 1'b0;
      end
      else if (!pend[s] && (ev_r ^ ev_p))
      begin
        pend[s] <= 1'b1;
        lead[s] <= ev_r;
        err_cnt[s] <= 8'h01;
      end
      else if (pend[s] && (ev_r || ev_p))
      begin
        pend[s] <= 1'b0;
        err_cnt[s] <= 8'h00;
        if (err_cnt[s] >= 8'(dpll_pkg::LOCK_UP_CYC))
        begin
          lock_side[s] <= 1'b0;
          good_cnt[s] <= 2'd0;
        end
        else if (good_cnt[s] == 2'(dpll_pkg::LOCK_GOOD_CNT - 1))
          lock_side[s] <= 1'b1;
        else
          good_cnt[s] <= good_cnt[s] + 2'd1;
        if (soft_cnt[s] != 3'(dpll_pkg::SOFT_CMP))
          soft_cnt[s] <= soft_cnt[s] + 3'd1;
      end
      else if (pend[s] && err_cnt[s] != 8'hff)
        err_cnt[s] <= err_cnt[s] + 8'h01;
      else if (!pend[s] && ev_r && ev_p)
      begin
        // coincident edges count as a good comparison
        if (good_cnt[s] == 2'(dpll_pkg::LOCK_GOOD_CNT - 1))
          lock_side[s] <= 1'b1;
        else
          good_cnt[s] <= good_cnt[s] + 2'd1;
      end
    end
    // pump drive; after restart the pulses of the first four comparisons are cut to a short limit
    wire limited = soft_cnt[s] != 3'(dpll_pkg::SOFT_CMP) &&
                   err_cnt[s] > 8'(dpll_pkg::SOFT_CYC);
    wire in_err  = pend[s] && !limited;
    wire blip    = active && ev_r && ev_p;
    always_ff @(posedge mclk)
    begin
      if (!reset_n || !active)
      begin
        pump_up[s] <= 1'b0;
        pump_dn[s] <= 1'b0;
        pump_oe[s] <= 1'b0;
      end
      else
      begin
        // lead of reference means fr above fp
        // a dead-zone blip drives both levels at once, so it nets zero
        pump_up[s] <= (in_err && (lead[s] == pol[s])) || blip;
        pump_dn[s] <= (in_err && (lead[s] != pol[s])) || blip;
        pump_oe[s] <= in_err || blip;
      end
    end
  end
  assign tx_pump = '{pump_up[0], pump_dn[0], pump_oe[0]};
  assign rx_pump = '{pump_up[1], pump_dn[1], pump_oe[1]};

  // ---------------------------------------------------------------------------
  // lock and monitor pin
  // ---------------------------------------------------------------------------
  logic [1:0] comp_tog;
  logic [1:0] ref_tog;
  // divided frequencies shown as toggles, half their rate
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      comp_tog <= 2'b00;
      ref_tog  <= 2'b00;
    end
    else
    begin
      comp_tog <= comp_tog ^ comp_rise;
      ref_tog  <= ref_tog ^ ref_tick;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      lock_detect      <= 1'b0;
      lock_monitor_out <= 1'b0;
    end
    else
    begin
      lock_detect <= &lock_side;
      if (!lockdet_out_select)
        lock_monitor_out <= &lock_side;
      else
        case (mon_sel)
          2'b00:   lock_monitor_out <= ref_tog[0];
          2'b10:   lock_monitor_out <= ref_tog[1];
          2'b01:   lock_monitor_out <= comp_tog[0];
          2'b11:   lock_monitor_out <= comp_tog[1];
          default: lock_monitor_out <= 1'b0;
        endcase
    end
  end
endmodule // dpll_ctrl

// *** testbench/dpll_ctrl_props.sv ***
// checker: port-level properties of the synthesizer control core
`timescale 1ns/100ps
module dpll_props #(
  parameter int FRAME_LEN = 24
) (
  input wire logic                 mclk,
  input wire logic                 reset_n,
  input wire logic                 serial_data,
  input wire logic                 serial_clock,
  input wire logic                 load_strobe,
  input wire logic                 power_save_n,
  input wire logic [1:0]           comp_in,
  input wire logic [1:0]           tx_prescaler_mod,
  input wire logic [1:0]           rx_prescaler_mod,
  input wire dpll_pkg::dpll_pump_t tx_pump,
  input wire dpll_pkg::dpll_pump_t rx_pump,
  input wire logic                 tx_pump_high_current,
  input wire logic                 rx_pump_high_current,
  input wire logic                 lock_monitor_out,
  input wire logic                 lock_detect
);
  // --------------------------------------------------------------
  // helpers: strobe age and comparison count since power save
  // --------------------------------------------------------------
  logic [3:0] le_age;
  logic [1:0] cmp_cnt;
  logic       le_d;
  logic       cmp_d;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // latched fields may only move within a few cycles of a strobe edge
  always_ff @(posedge mclk)
  begin
    le_d <= load_strobe;
    if (!reset_n || (load_strobe && !le_d))
      le_age <= 4'h0;
    else if (le_age != 4'hf)
      le_age <= le_age + 4'h1;
  end
  // counted at the pin, so never below what the core has seen
  always_ff @(posedge mclk)
  begin
    cmp_d <= comp_in[0];
    if (!reset_n || !power_save_n)
      cmp_cnt <= 2'h0;
    else if (comp_in[0] && !cmp_d && cmp_cnt != 2'h3)
      cmp_cnt <= cmp_cnt + 2'h1;
  end
  sequence save_held_s;
    !power_save_n [*4];
  endsequence
  sequence save_entry_s;
    $fell(power_save_n);
  endsequence
  float_save_a: assert property (save_held_s |-> !tx_pump.oe && !rx_pump.oe)
    else $error("pump driven during power save");
  save_entry_a: assert property (save_entry_s |-> ##[1:4] !rx_pump.oe)
    else $error("pump still driven after power save entry");
  pump_sense_a: assert property (
    tx_pump.oe == (tx_pump.up || tx_pump.down)
    && rx_pump.oe == (rx_pump.up || rx_pump.down))
    else $error("pump enable disagrees with its levels");
  modulus_set_a: assert property (tx_prescaler_mod != dpll_pkg::PRE_RX_LO
    && rx_prescaler_mod != dpll_pkg::PRE_TX_HI)
    else $error("modulus pair outside its range");
  latch_move_a: assert property ($changed({tx_prescaler_mod, rx_prescaler_mod})
    |-> le_age < 4'h8) else $error("modulus moved without a load");
  current_move_a: assert property ($changed({tx_pump_high_current,
    rx_pump_high_current}) |-> le_age < 4'h8)
    else $error("pump current moved without a load");
  relock_count_a: assert property ($rose(lock_detect) |-> cmp_cnt == 2'h3)
    else $error("lock rose before three comparisons");
  reset_value_a: assert property ($rose(reset_n) |-> !lock_detect &&
    tx_prescaler_mod == dpll_pkg::PRE_MID && !tx_pump.oe
    && rx_prescaler_mod == dpll_pkg::PRE_RX_LO)
    else $error("wrong value after reset");
endmodule // dpll_props

bind dpll_ctrl dpll_props #(.FRAME_LEN(FRAME_LEN)) u_props (
  .mclk(mclk), .reset_n(reset_n), .serial_data(serial_data),
  .serial_clock(serial_clock), .load_strobe(load_strobe),
  .power_save_n(power_save_n), .comp_in(comp_in),
  .tx_prescaler_mod(tx_prescaler_mod), .rx_prescaler_mod(rx_prescaler_mod),
  .tx_pump(tx_pump), .rx_pump(rx_pump),
  .tx_pump_high_current(tx_pump_high_current),
  .rx_pump_high_current(rx_pump_high_current),
  .lock_monitor_out(lock_monitor_out), .lock_detect(lock_detect));

// *** testbench/dpll_host.sv ***
// host model: shifts frames into the serial port and strobes them in
`timescale 1ns/100ps
module dpll_host #(
  parameter int HALF = 4  // serial clock half period in mclk cycles
) (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [23:0] frame,
  output logic             serial_data = 1'b0,
  output logic             serial_clock = 1'b0,
  output logic             load_strobe = 1'b0,
  output logic             busy = 1'b0
);
  // one frame per go; the serial clock stands low between frames
  always @(posedge mclk)
  begin
    if (go && !busy)
    begin
      busy <= 1'b1;
      for (int i = 23; i >= 0; i--)
      begin
        serial_data <= frame[i];
        repeat (HALF) @(posedge mclk);
        serial_clock <= 1'b1;
        repeat (HALF) @(posedge mclk);
        serial_clock <= 1'b0;
      end
      serial_data <= ~frame[0];  // stale bit must not look held
      load_strobe <= 1'b1;
      repeat (HALF) @(posedge mclk);
      load_strobe <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule // dpll_host

// *** testbench/dpll_ctrl_tb.sv ***
// testbench: serial loading, monitor routing, pump and power save
`timescale 1ns/100ps
module dpll_ctrl_tb;
  logic                 mclk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 power_save_n = 1'b0;
  logic [1:0]           comp_in = 2'h0;
  logic                 go = 1'b0;
  logic [23:0]          frame = 24'h00_0000;
  logic                 sdata, sclk, strobe, busy;
  logic [1:0]           tx_mod, rx_mod;
  dpll_pkg::dpll_pump_t tx_pump, rx_pump;
  logic                 tx_hi, rx_hi, mon, lock;
  int                   bad_count = 0;
  int                   checks_done = 0;
  int                   cyc = 0;
  int                   cp = 0;
  int                   cc = 0;
  int                   tg, up, dn, oe, ml;
  int                   exp_t [4] = '{20, 10, 33, 10};
  always #25 mclk = ~mclk;
  dpll_ctrl #(.FRAME_LEN(24)) DUT (.mclk(mclk), .reset_n(reset_n),
    .serial_data(sdata), .serial_clock(sclk), .load_strobe(strobe),
    .power_save_n(power_save_n), .comp_in(comp_in),
    .tx_prescaler_mod(tx_mod), .rx_prescaler_mod(rx_mod),
    .tx_pump(tx_pump), .rx_pump(rx_pump), .tx_pump_high_current(tx_hi),
    .rx_pump_high_current(rx_hi), .lock_monitor_out(mon),
    .lock_detect(lock));
  dpll_host u_host (.mclk(mclk), .go(go), .frame(frame), .serial_data(sdata),
    .serial_clock(sclk), .load_strobe(strobe), .busy(busy));
  // comparison pulses every cp cycles on both sides; cp 0 keeps quiet
  always @(posedge mclk)
  begin
    cc <= (cc + 1 >= cp) ? 0 : cc + 1;
    comp_in <= {2{cp != 0 && cc == 0}};
  end
  // frame builders: last two bits shifted carry the destination
  function automatic logic [23:0] ref_f(input logic [1:0] d,
    input logic [13:0] r, input logic [5:0] b);
    return {2'h0, b, r, d[0], d[1]};
  endfunction
  function automatic logic [23:0] cnt_f(input logic [1:0] d,
    input logic [10:0] n, input logic [6:0] a);
    return {4'h0, n, a, d[0], d[1]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic near(input string nm, input int e, input int g, input int t);
    checks_done++;
    if (g < e - t || g > e + t)
    begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // hand a frame to the host, wait for it, let the latch settle
  task automatic send(input logic [23:0] f);
    int n;
    n = 0;
    @(posedge mclk);
    frame <= f;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    while (busy && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    repeat (8) @(posedge mclk);
    @(negedge mclk);
  endtask
  // count monitor toggles and tx pump activity over n cycles
  task automatic watch(input int n);
    logic p;
    p = mon;
    {tg, up, dn, oe, ml} = '0;
    repeat (n)
    begin
      @(negedge mclk);
      tg += (mon !== p);
      p = mon;
      up += (tx_pump.oe && tx_pump.up);
      dn += (tx_pump.oe && tx_pump.down);
      oe += tx_pump.oe;
      ml += (mon !== lock);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard: far above the few thousand cycles the run needs
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    chk("tx modulus", 8'h1, {6'h0, tx_mod});
    chk("rx modulus", 8'h2, {6'h0, rx_mod});
    chk("tx current", 8'h0, {7'h0, tx_hi});
    repeat (24) @(posedge mclk);
    power_save_n <= 1'b1;
    cp = 10;
    send(ref_f(2'b10, 14'd3, 6'b000011));
    chk("rx modulus", 8'h1, {6'h0, rx_mod});
    chk("rx current", 8'h0, {7'h0, rx_hi});
    for (int m = 0; m < 4; m++)
    begin
      send(ref_f(2'b00, 14'd5, {m[0], m[1], 4'hf}));
      watch(100);
      near("monitor toggles", exp_t[m], tg, 1);
    end
    chk("tx modulus", 8'h0, {6'h0, tx_mod});
    chk("tx current", 8'h1, {7'h0, tx_hi});
    send(cnt_f(2'b01, 11'd2047, 7'd127));
    send(cnt_f(2'b11, 11'd3, 7'd0));
    chk("tx modulus", 8'h0, {6'h0, tx_mod});
    chk("rx modulus", 8'h1, {6'h0, rx_mod});
    cp = 0;
    for (int p = 1; p >= 0; p--)
    begin
      send(ref_f(2'b00, 14'd5, {4'b0001, p[0], 1'b1}));
      watch(200);
      chk("pump sense", {7'h0, p[0]}, {7'h0, up > dn});
      near("monitor vs lock", 0, ml, 0);
    end
    cp = 5;
    watch(100);
    chk("pump pulses", 8'h1, {7'h0, oe > 0});
    @(posedge mclk);
    power_save_n <= 1'b0;
    repeat (4) @(posedge mclk);
    watch(40);
    near("pump drive in save", 0, oe, 0);
    send(ref_f(2'b10, 14'd3, 6'b000000));
    chk("rx modulus", 8'h2, {6'h0, rx_mod});
    @(posedge mclk);
    power_save_n <= 1'b1;
    watch(100);
    chk("tx modulus", 8'h0, {6'h0, tx_mod});
    chk("pump pulses", 8'h1, {7'h0, oe > 0});
    // soft start: long error windows are cut right after a release
    cp = 0;
    send(ref_f(2'b00, 14'd20, 6'b000111));
    @(posedge mclk);
    power_save_n <= 1'b0;
    repeat (4) @(posedge mclk);
    power_save_n <= 1'b1;
    watch(80);
    chk("soft start", 8'h1,
      {7'h0, oe > 0 && oe <= 3 * dpll_pkg::SOFT_CYC});
    // relock: both dividers at 5, comparison edges meet reference ticks
    cp = 5;
    send(ref_f(2'b10, 14'd5, 6'b000010));
    send(ref_f(2'b00, 14'd5, 6'b000111));
    @(posedge mclk);
    power_save_n <= 1'b0;
    repeat (4) @(posedge mclk);
    // release in the phase that lines comparison edges up with ticks
    while (cc != 1)
      @(posedge mclk);
    power_save_n <= 1'b1;
    repeat (30) @(negedge mclk);
    chk("lock after relock", 8'h1, {7'h0, lock});
    chk("monitor shows lock", 8'h1, {7'h0, mon});
    cp = 0;
    repeat (30) @(negedge mclk);
    chk("lock after error", 8'h0, {7'h0, lock});
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    chk("tx modulus", 8'h1, {6'h0, tx_mod});
    stop_test();
  end
endmodule // dpll_ctrl_tb
